// ---- pcc_pkg.sv ----
// Purpose: Shared constants for the PLL clock select control block
// Assumes: AXI4-Lite slave with 8-bit byte addresses, 32-bit data
// Notes: Register byte address is four times the register index
package pcc_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] PCC_CTRL_IDX = 8'h1C;
    localparam logic [7:0] PCC_BW_IDX = 8'h1D;
    localparam logic [7:0] PCC_PROG_IDX = 8'h1E;
    localparam logic [7:0] PCC_CTRL_ADDR = {PCC_CTRL_IDX[5:0], 2'b00};
    localparam logic [7:0] PCC_BW_ADDR = {PCC_BW_IDX[5:0], 2'b00};
    localparam logic [7:0] PCC_PROG_ADDR = {PCC_PROG_IDX[5:0], 2'b00};

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int PCC_IE_BIT = 7;
    localparam int PCC_FLAG_BIT = 6;
    localparam int PCC_PON_BIT = 5;
    localparam int PCC_BCS_BIT = 4;
    localparam int PCC_AUTO_BIT = 7;
    localparam int PCC_LOCK_BIT = 6;
    localparam int PCC_ACQ_BIT = 5;
    localparam int PCC_XLD_BIT = 4;
    localparam int PCC_MUL_LSB = 4;
    localparam int PCC_VRS_LSB = 0;

    // ****************************************************************
    // Reset values and fixed codes
    // ****************************************************************
    localparam logic PCC_PON_RST = 1'b1;
    localparam logic [3:0] PCC_MUL_RST = 4'h6;
    localparam logic [3:0] PCC_VRS_RST = 4'h6;
    localparam logic [3:0] PCC_CTRL_UNIMPL = 4'hF;
    localparam logic [1:0] PCC_SWITCH_EDGES = 2'h3;
    localparam logic [1:0] PCC_RESP_OKAY = 2'h0;
    localparam logic [1:0] PCC_RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        PCC_SW_RUN = 3'b001,
        PCC_SW_DRAIN = 3'b010,
        PCC_SW_FILL = 3'b100
    } pcc_sw_state_e;

endpackage

// ---- pcc_clk_if.sv ----
// Purpose: Carries source clock edges and selection to the switcher
// Assumes: All signals on sys_clk_i
// Notes: Edge strobes are one-cycle pulses
interface pcc_clk_if;
    logic xclk_rise;
    logic vclk_rise;
    logic select_vco;
    logic run;
    logic clk_out;
    logic busy;

    modport ctrl (output xclk_rise, output vclk_rise, output select_vco,
                  output run, input clk_out, input busy);
    modport sw (input xclk_rise, input vclk_rise, input select_vco,
                input run, output clk_out, output busy);
endinterface

// ---- pcc_sync.sv ----
// Purpose: Two-flop synchroniser for asynchronous inputs
// Assumes: Inputs are levels from pins or other clocks
// Notes: Only the second stage is visible to other logic
module pcc_sync #(
    parameter int W = 1
) (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    always_comb begin
        meta_d = async_i;
        sync_d = meta_q;
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else if (ce_i) begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_o = sync_q;
endmodule

// ---- pcc_switch.sv ----
// Purpose: Glitch-free source switch and divide-by-two of base clock
// Assumes: Source edges arrive as sampled strobes on sys_clk_i
// Notes: Output is frozen while a source change is completed
module pcc_switch
    import pcc_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    pcc_clk_if.sw cif
);
    pcc_sw_state_e state_q, state_d;
    logic cur_q, cur_d;
    logic out_q, out_d;
    logic [1:0] cnt_q, cnt_d;
    logic old_rise;
    logic new_rise;

    always_comb begin
        old_rise = cur_q ? cif.vclk_rise : cif.xclk_rise;
        new_rise = cif.select_vco ? cif.vclk_rise : cif.xclk_rise;
        state_d = state_q;
        cur_d = cur_q;
        out_d = out_q;
        cnt_d = cnt_q;
        case (state_q)
            PCC_SW_RUN: begin
                if (!cif.run) begin
                    out_d = 1'b0;
                    cur_d = cif.select_vco;
                end else if (cif.select_vco != cur_q) begin
                    state_d = PCC_SW_DRAIN;
                    cnt_d = 2'h0;
                end else if (old_rise) begin
                    out_d = ~out_q;
                end
            end
            PCC_SW_DRAIN: begin
                if (old_rise) begin
                    cnt_d = cnt_q + 2'h1;
                end
                if (old_rise && cnt_q + 2'h1 == PCC_SWITCH_EDGES) begin
                    state_d = PCC_SW_FILL;
                    cnt_d = 2'h0;
                end
            end
            PCC_SW_FILL: begin
                if (new_rise) begin
                    cnt_d = cnt_q + 2'h1;
                end
                if (new_rise && cnt_q + 2'h1 == PCC_SWITCH_EDGES) begin
                    state_d = PCC_SW_RUN;
                    cur_d = cif.select_vco;
                end
            end
            default: begin
                state_d = PCC_SW_RUN;
            end
        endcase
        if (!cif.run) begin
            state_d = PCC_SW_RUN;
            out_d = 1'b0;
            cur_d = cif.select_vco;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            state_q <= PCC_SW_RUN;
            cur_q <= 1'b0;
            out_q <= 1'b0;
            cnt_q <= 2'h0;
        end else if (ce_i) begin
            state_q <= state_d;
            cur_q <= cur_d;
            out_q <= out_d;
            cnt_q <= cnt_d;
        end
    end

    assign cif.clk_out = out_q;
    assign cif.busy = (state_q != PCC_SW_RUN);
endmodule

// ---- pcc_ctrl.sv ----
// Purpose: Register file, interlocks and base clock select of a PLL
// Assumes: AXI4-Lite on sys_clk_i; analog status arrives asynchronously
// Notes: Source clocks are sampled, so each must stay below 50 MHz
//
// Design decision made here: the AXI4-Lite interface to the registers.
module pcc_ctrl
    import pcc_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic oscillator_enable_i,
    input wire logic crystal_clock_i,
    input wire logic vco_clock_i,
    input wire logic lock_detect_i,
    input wire logic tracking_detect_i,
    input wire logic crystal_lost_i,
    output logic base_clock_out_o,
    output logic clockgen_irq_o,
    output logic oscillator_run_o,
    output logic pll_enable_o,
    output logic [3:0] feedback_multiplier_o,
    output logic [3:0] vco_range_multiplier_o,
    output logic bandwidth_auto_o,
    output logic tracking_mode_select_o
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic addr_known(input logic [7:0] a);
        return (a == PCC_CTRL_ADDR) || (a == PCC_BW_ADDR) ||
               (a == PCC_PROG_ADDR);
    endfunction

    function automatic logic [3:0] eff_mul(input logic [3:0] m);
        return (m == 4'h0) ? 4'h1 : m;
    endfunction

    // ****************************************************************
    // Input synchronisers and edge strobes
    // ****************************************************************
    logic [4:0] pin_sync;
    logic xclk_s, vclk_s, lock_s, trk_s, lost_s;
    logic xclk_prev_q, xclk_prev_d;
    logic vclk_prev_q, vclk_prev_d;
    logic lock_prev_q, lock_prev_d;

    pcc_sync #(.W(5)) u_sync (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .ce_i(ce_i),
        .async_i({crystal_clock_i, vco_clock_i, lock_detect_i,
                  tracking_detect_i, crystal_lost_i}),
        .sync_o(pin_sync)
    );

    assign {xclk_s, vclk_s, lock_s, trk_s, lost_s} = pin_sync;

    always_comb begin
        xclk_prev_d = xclk_s;
        vclk_prev_d = vclk_s;
        lock_prev_d = lock_s;
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            xclk_prev_q <= 1'b0;
            vclk_prev_q <= 1'b0;
            lock_prev_q <= 1'b0;
        end else if (ce_i) begin
            xclk_prev_q <= xclk_prev_d;
            vclk_prev_q <= vclk_prev_d;
            lock_prev_q <= lock_prev_d;
        end
    end

    // ****************************************************************
    // Register state
    // ****************************************************************
    logic ie_q, ie_d;
    logic flag_q, flag_d;
    logic pon_q, pon_d;
    logic bcs_q, bcs_d;
    logic auto_q, auto_d;
    logic acq_q, acq_d;
    logic xld_q, xld_d;
    logic [3:0] mul_q, mul_d;
    logic [3:0] vrs_q, vrs_d;
    logic do_wr;
    logic do_rd;
    logic [7:0] wr_addr;
    logic [7:0] wr_byte;
    logic wr_lane;
    logic lock_view;
    logic [7:0] ctrl_view;
    logic [7:0] bw_view;
    logic [7:0] prog_view;

    always_comb begin
        lock_view = auto_q & lock_s;
        ctrl_view = {ie_q & auto_q, flag_q & auto_q, pon_q, bcs_q,
                     PCC_CTRL_UNIMPL};
        bw_view = {auto_q, lock_view, auto_q ? trk_s : acq_q,
                   bcs_q & xld_q & lost_s, 4'h0};
        prog_view = {mul_q, vrs_q};
    end

    always_comb begin
        ie_d = ie_q;
        flag_d = flag_q;
        pon_d = pon_q;
        bcs_d = bcs_q;
        auto_d = auto_q;
        acq_d = acq_q;
        xld_d = xld_q;
        mul_d = mul_q;
        vrs_d = vrs_q;
        if (do_wr && wr_lane && wr_addr == PCC_CTRL_ADDR) begin
            if (auto_q) begin
                ie_d = wr_byte[PCC_IE_BIT];
            end
            if (wr_byte[PCC_BCS_BIT] != bcs_q) begin
                // Select changes: PLL bit left alone
                if (!wr_byte[PCC_BCS_BIT]) begin
                    bcs_d = 1'b0;
                end else if (pon_q && vrs_q != 4'h0) begin
                    bcs_d = 1'b1;
                end
            end else if (!bcs_q) begin
                pon_d = wr_byte[PCC_PON_BIT];
            end
        end
        if (do_wr && wr_lane && wr_addr == PCC_BW_ADDR) begin
            auto_d = wr_byte[PCC_AUTO_BIT];
            if (!auto_q) begin
                acq_d = wr_byte[PCC_ACQ_BIT];
            end
            xld_d = wr_byte[PCC_XLD_BIT];
        end
        if (do_wr && wr_lane && wr_addr == PCC_PROG_ADDR && !pon_q) begin
            mul_d = wr_byte[PCC_MUL_LSB +: 4];
            vrs_d = wr_byte[PCC_VRS_LSB +: 4];
        end
        if (!auto_d) begin
            ie_d = 1'b0;
        end
        if (do_rd && s_axi_araddr == PCC_CTRL_ADDR) begin
            flag_d = 1'b0;
        end
        if (auto_q && lock_s != lock_prev_q) begin
            flag_d = 1'b1;
        end
        if (!auto_q) begin
            flag_d = 1'b0;
        end
        if (!pon_d || vrs_d == 4'h0) begin
            bcs_d = 1'b0;
        end
        if (!oscillator_enable_i) begin
            bcs_d = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            ie_q <= 1'b0;
            flag_q <= 1'b0;
            pon_q <= PCC_PON_RST;
            bcs_q <= 1'b0;
            auto_q <= 1'b0;
            acq_q <= 1'b0;
            xld_q <= 1'b0;
            mul_q <= PCC_MUL_RST;
            vrs_q <= PCC_VRS_RST;
        end else if (ce_i) begin
            ie_q <= ie_d;
            flag_q <= flag_d;
            pon_q <= pon_d;
            bcs_q <= bcs_d;
            auto_q <= auto_d;
            acq_q <= acq_d;
            xld_q <= xld_d;
            mul_q <= mul_d;
            vrs_q <= vrs_d;
        end
    end

    // ****************************************************************
    // AXI4-Lite write channel
    // ****************************************************************
    logic aw_full_q, aw_full_d;
    logic w_full_q, w_full_d;
    logic [7:0] awaddr_q, awaddr_d;
    logic [7:0] wbyte_q, wbyte_d;
    logic wlane_q, wlane_d;
    logic awready_q, awready_d;
    logic wready_q, wready_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;

    assign do_wr = aw_full_q & w_full_q & ~bvalid_q;
    assign wr_addr = awaddr_q;
    assign wr_byte = wbyte_q;
    assign wr_lane = wlane_q;

    always_comb begin
        aw_full_d = aw_full_q;
        w_full_d = w_full_q;
        awaddr_d = awaddr_q;
        wbyte_d = wbyte_q;
        wlane_d = wlane_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        if (s_axi_awvalid && awready_q) begin
            aw_full_d = 1'b1;
            awaddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_q) begin
            w_full_d = 1'b1;
            wbyte_d = s_axi_wdata[7:0];
            wlane_d = s_axi_wstrb[0];
        end
        if (do_wr) begin
            aw_full_d = 1'b0;
            w_full_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = addr_known(awaddr_q) ? PCC_RESP_OKAY
                                           : PCC_RESP_SLVERR;
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        awready_d = ~aw_full_d & ~bvalid_d;
        wready_d = ~w_full_d & ~bvalid_d;
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awaddr_q <= 8'h00;
            wbyte_q <= 8'h00;
            wlane_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= PCC_RESP_OKAY;
        end else if (ce_i) begin
            aw_full_q <= aw_full_d;
            w_full_q <= w_full_d;
            awaddr_q <= awaddr_d;
            wbyte_q <= wbyte_d;
            wlane_q <= wlane_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
        end
    end

    // ****************************************************************
    // AXI4-Lite read channel
    // ****************************************************************
    logic arready_q, arready_d;
    logic rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;

    assign do_rd = s_axi_arvalid & arready_q;

    always_comb begin
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (do_rd) begin
            rvalid_d = 1'b1;
            rresp_d = PCC_RESP_OKAY;
            case (s_axi_araddr)
                PCC_CTRL_ADDR: rdata_d = {24'h000000, ctrl_view};
                PCC_BW_ADDR: rdata_d = {24'h000000, bw_view};
                PCC_PROG_ADDR: rdata_d = {24'h000000, prog_view};
                default: begin
                    rdata_d = 32'h00000000;
                    rresp_d = PCC_RESP_SLVERR;
                end
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        arready_d = ~rvalid_d;
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= PCC_RESP_OKAY;
        end else if (ce_i) begin
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    // ****************************************************************
    // Base clock switch
    // ****************************************************************
    pcc_clk_if cif ();

    assign cif.xclk_rise = xclk_s & ~xclk_prev_q;
    assign cif.vclk_rise = vclk_s & ~vclk_prev_q;
    assign cif.select_vco = bcs_q;
    assign cif.run = oscillator_enable_i;

    pcc_switch u_switch (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .ce_i(ce_i),
        .cif(cif)
    );

    // ****************************************************************
    // Registered outputs
    // ****************************************************************
    logic irq_q, irq_d;
    logic osc_q, osc_d;
    logic pll_q, pll_d;
    logic [3:0] fbm_q, fbm_d;

    always_comb begin
        irq_d = flag_d & ie_d & auto_d;
        osc_d = oscillator_enable_i;
        pll_d = oscillator_enable_i & pon_d & (vrs_d != 4'h0);
        fbm_d = eff_mul(mul_d);
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            irq_q <= 1'b0;
            osc_q <= 1'b0;
            pll_q <= 1'b0;
            fbm_q <= PCC_MUL_RST;
        end else if (ce_i) begin
            irq_q <= irq_d;
            osc_q <= osc_d;
            pll_q <= pll_d;
            fbm_q <= fbm_d;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign base_clock_out_o = cif.clk_out;
    assign clockgen_irq_o = irq_q;
    assign oscillator_run_o = osc_q;
    assign pll_enable_o = pll_q;
    assign feedback_multiplier_o = fbm_q;
    assign vco_range_multiplier_o = vrs_q;
    assign bandwidth_auto_o = auto_q;
    assign tracking_mode_select_o = acq_q;
endmodule

// ---- pcc_ctrl_monitor.sv ----
// Purpose: Port checks of the PLL clock select control block
// Assumes: One clock, synchronous active-low reset
// Notes: Attached to pcc_ctrl by bind
module pcc_ctrl_monitor (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic oscillator_enable_i,
    input wire logic base_clock_out_o,
    input wire logic clockgen_irq_o,
    input wire logic oscillator_run_o,
    input wire logic pll_enable_o,
    input wire logic [3:0] feedback_multiplier_o,
    input wire logic [3:0] vco_range_multiplier_o,
    input wire logic bandwidth_auto_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // Checks
    // ****
    default clocking @(posedge sys_clk_i);
    endclocking
    default disable iff (!nrst_i);
    a_irq_auto: assert property (
        clockgen_irq_o |-> bandwidth_auto_o) else $error("irq in manual");
    a_osc_follow: assert property (
        $past(nrst_i) |-> oscillator_run_o == $past(oscillator_enable_i))
        else $error("osc run lag");
    a_pll_osc: assert property (
        pll_enable_o |-> oscillator_run_o) else $error("pll without osc");
    a_pll_range: assert property (
        pll_enable_o |-> vco_range_multiplier_o != 4'h0)
        else $error("pll with zero range");
    a_mul_map: assert property (
        feedback_multiplier_o != 4'h0) else $error("multiplier zero");
    a_stop_base: assert property (
        !oscillator_enable_i [*2] |=> !base_clock_out_o)
        else $error("base clock in stop");
    a_write_lat: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid) else $error("write answer late");
    a_read_lat: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
endmodule

bind pcc_ctrl pcc_ctrl_monitor u_mon (
    .sys_clk_i, .nrst_i, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .oscillator_enable_i, .base_clock_out_o,
    .clockgen_irq_o, .oscillator_run_o, .pll_enable_o,
    .feedback_multiplier_o, .vco_range_multiplier_o, .bandwidth_auto_o
);

// ---- pcc_sim_model.sv ----
// Purpose: System integration partner of the clock block
// Assumes: Base clock is a register on sys_clk_i
// Notes: Counts base clock edges; stop_i models stop standby
module pcc_sim_model (
    input wire logic sys_clk_i,
    input wire logic base_clock_i,
    input wire logic stop_i,
    input wire logic clr_i,
    output logic osc_enable_o,
    output int toggles_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // Enable and edge count
    // ****
    logic last_q;
    always @(posedge sys_clk_i) begin
        osc_enable_o <= !stop_i;
        last_q <= base_clock_i;
        if (clr_i)
            toggles_o <= 0;
        else if (base_clock_i != last_q)
            toggles_o <= toggles_o + 1;
    end
endmodule

// ---- tb_top.sv ----
// Purpose: Self-checking bench of the PLL clock select control
// Assumes: Source clocks run free below 50 MHz
// Notes: Register bus driven by AXI4-Lite tasks
module tb_top
    import pcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // Signals and instances
    // ****
    localparam logic [23:0] STEPS [12] = '{24'h780066, 24'h700F0F,
        24'h780000, 24'h703F0F, 24'h702F2F, 24'h703F2F, 24'h700F0F,
        24'h786666, 24'h702F2F, 24'h703F3F, 24'h701F3F, 24'h700F2F};
    logic sys_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic crystal_clock_i = 1'b0;
    logic vco_clock_i = 1'b0;
    logic lock_detect_i = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic stop = 1'b0;
    logic clr = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, oscillator_enable_i, base_clock_out_o;
    logic clockgen_irq_o, oscillator_run_o, pll_enable_o;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [3:0] feedback_multiplier_o, vco_range_multiplier_o;
    logic tracking_mode_select_o;
    logic [4:0] pll_fb;
    int toggles, bad_count = 0, check_count = 0;

    pcc_ctrl u_dut (
        .sys_clk_i, .nrst_i, .ce_i(1'b1), .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .oscillator_enable_i,
        .crystal_clock_i, .vco_clock_i, .lock_detect_i,
        .tracking_detect_i(1'b0), .crystal_lost_i(1'b0), .base_clock_out_o,
        .clockgen_irq_o, .oscillator_run_o, .pll_enable_o,
        .feedback_multiplier_o, .vco_range_multiplier_o,
        .bandwidth_auto_o(), .tracking_mode_select_o
    );
    pcc_sim_model u_sim (.sys_clk_i, .base_clock_i(base_clock_out_o),
        .stop_i(stop), .clr_i(clr), .osc_enable_o(oscillator_enable_i),
        .toggles_o(toggles));
    assign pll_fb = {pll_enable_o, feedback_multiplier_o};

    initial begin
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    always #40 crystal_clock_i = ~crystal_clock_i;
    always #30 vco_clock_i = ~vco_clock_i;
    // ****
    // Tasks
    // ****
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask
    task automatic lim(input int n);
        if (n >= 50) begin
            chk(32'(n), 32'h0);
            end_of_test;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      input logic [1:0] r = PCC_RESP_OKAY);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge sys_clk_i);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        lim(n);
        chk(32'(s_axi_bresp), 32'(r));
        wt(1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e,
                      input logic [1:0] r = PCC_RESP_OKAY);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge sys_clk_i);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'b0;
        lim(n);
        chk(s_axi_rdata, {24'h0, e});
        chk(32'(s_axi_rresp), 32'(r));
        wt(1);
    endtask
    task automatic count(input int n);
        clr <= 1'b1;
        wt(1);
        clr <= 1'b0;
        wt(n);
    endtask
    // ****
    // Scenarios
    // ****
    task automatic t_reset;
        rd(PCC_CTRL_ADDR, 8'h2F);
        rd(PCC_BW_ADDR, 8'h00);
        rd(PCC_PROG_ADDR, 8'h66);
        wr(8'h7C, 8'hFF, PCC_RESP_SLVERR);
        rd(8'h7C, 8'h00, PCC_RESP_SLVERR);
        $display("reset test done");
    endtask
    task automatic t_base;
        count(100);
        chk(32'(toggles >= 11 && toggles <= 14), 32'h1);
        wr(PCC_CTRL_ADDR, 8'h3F);
        count(12);
        chk(32'(toggles), 32'h0);
        wt(50);
        count(100);
        chk(32'(toggles >= 15 && toggles <= 18), 32'h1);
        $display("base clock test done");
    endtask
    task automatic t_stop;
        stop <= 1'b1;
        wt(6);
        chk(32'({base_clock_out_o, pll_enable_o}), 32'h0);
        stop <= 1'b0;
        wt(4);
        rd(PCC_CTRL_ADDR, 8'h2F);
        $display("stop test done");
    endtask
    task automatic t_lock;
        for (int i = 0; i < 12; i++) begin
            logic [23:0] s;
            s = STEPS[i];
            wr(s[23:16], s[15:8]);
            rd(s[23:16], s[7:0]);
            if (i == 5)
                chk(32'(pll_fb), 32'h1);
        end
        $display("interlock test done");
    endtask
    task automatic t_irq;
        lock_detect_i <= 1'b1;
        wt(8);
        rd(PCC_CTRL_ADDR, 8'h2F);
        rd(PCC_BW_ADDR, 8'h00);
        wr(PCC_CTRL_ADDR, 8'hAF);
        rd(PCC_CTRL_ADDR, 8'h2F);
        wr(PCC_BW_ADDR, 8'h20);
        rd(PCC_BW_ADDR, 8'h20);
        chk(32'(tracking_mode_select_o), 32'h1);
        wr(PCC_BW_ADDR, 8'h80);
        wr(PCC_CTRL_ADDR, 8'hAF);
        rd(PCC_BW_ADDR, 8'hC0);
        lock_detect_i <= 1'b0;
        wt(8);
        chk(32'(clockgen_irq_o), 32'h1);
        rd(PCC_CTRL_ADDR, 8'hEF);
        rd(PCC_CTRL_ADDR, 8'hAF);
        chk(32'(clockgen_irq_o), 32'h0);
        wr(PCC_CTRL_ADDR, 8'h2F);
        lock_detect_i <= 1'b1;
        wt(8);
        chk(32'(clockgen_irq_o), 32'h0);
        rd(PCC_CTRL_ADDR, 8'h6F);
        wr(PCC_CTRL_ADDR, 8'hAF);
        nrst_i <= 1'b0;
        wt(3);
        nrst_i <= 1'b1;
        wt(1);
        rd(PCC_CTRL_ADDR, 8'h2F);
        rd(PCC_BW_ADDR, 8'h00);
        $display("interrupt test done");
    endtask

    initial begin
        wt(3);
        nrst_i <= 1'b1;
        wt(1);
        t_reset;
        t_base;
        t_stop;
        t_lock;
        t_irq;
        end_of_test;
    end
endmodule
